//--- verilog/lor_datapath.sv
`timescale 1ns/100ps
`include "lor_consts.svh"

// Notes on behaviour
// - or memory nibble into accumulator only
// - or working register with immediate into accumulator
// - or memory into accumulator and memory
// - or immediate into accumulator and working register
// - rotate memory left through carry, write both
// - rotate memory right through carry, write both
module lor_datapath (
  input wire logic mclk,
  input wire logic srst,
  input wire logic [15:0] instr,
  input wire logic instrValid,
  output logic [6:0] memAddr,
  input wire logic [3:0] memRdata,
  output logic [3:0] wrSel,
  input wire logic [3:0] wrRdata,
  output logic memWe,
  output logic [6:0] memWaddr,
  output logic [3:0] memWdata,
  output logic wrWe,
  output logic [3:0] wrWaddr,
  output logic [3:0] wrWdata,
  output logic [3:0] acc,
  output logic carryFlag,
  output logic zeroFlag
);

  // ----------------------------------------------------------------
  // decode
  // ----------------------------------------------------------------
  wire logic [8:0] op9 = instr[`LOR_OP9_HI:`LOR_OP9_LO]; // long opcode field
  wire logic [7:0] op8 = instr[`LOR_OP9_HI:`LOR_OP8_LO]; // short opcode field
  wire logic [3:0] imm = instr[`LOR_IMM_HI:`LOR_IMM_LO]; // immediate nibble
  lor_pkg::lor_op_t op; // decoded operation

  // memory and register selects go straight out so the read data
  // returns in the same cycle the instruction is presented
  assign memAddr = instr[`LOR_ADDR_HI:`LOR_ADDR_LO];
  assign wrSel = instr[`LOR_WSEL_HI:`LOR_WSEL_LO];

  // opcode match; an unknown word decodes to no operation
  always_comb
  begin
    op = lor_pkg::LOR_NONE;
    if (!instrValid)
      op = lor_pkg::LOR_NONE; // idle cycle
    else if (op9 == `LOR_OP_OR_MEM)
      op = lor_pkg::LOR_OR_MEM;
    else if (op9 == `LOR_OP_ORWB_MEM)
      op = lor_pkg::LOR_ORWB_MEM;
    else if (op9 == `LOR_OP_ROT_LEFT)
      op = lor_pkg::LOR_ROT_LEFT;
    else if (op9 == `LOR_OP_ROT_RIGHT)
      op = lor_pkg::LOR_ROT_RIGHT;
    else if (op8 == `LOR_OP_OR_IMM)
      op = lor_pkg::LOR_OR_IMM;
    else if (op8 == `LOR_OP_ORWB_IMM)
      op = lor_pkg::LOR_ORWB_IMM;
  end

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  logic [3:0] acc_ff; // accumulator
  logic carry_ff; // carry flag
  logic zero_ff; // zero flag
  logic memWe_ff; // memory write strobe, one cycle
  logic [6:0] memWaddr_ff; // memory write address
  logic [3:0] memWdata_ff; // memory write data
  logic wrWe_ff; // working register write strobe, one cycle
  logic [3:0] wrWaddr_ff; // working register write index
  logic [3:0] wrWdata_ff; // working register write data

  // ----------------------------------------------------------------
  // execute
  // ----------------------------------------------------------------
  wire logic isMemOr = (op == lor_pkg::LOR_OR_MEM) || (op == lor_pkg::LOR_ORWB_MEM);
  wire logic isImmOr = (op == lor_pkg::LOR_OR_IMM) || (op == lor_pkg::LOR_ORWB_IMM);
  wire logic isRotL = (op == lor_pkg::LOR_ROT_LEFT);
  wire logic isRotR = (op == lor_pkg::LOR_ROT_RIGHT);
  wire logic isRot = isRotL || isRotR;
  wire logic [3:0] orA = isImmOr ? wrRdata : memRdata; // first or operand
  wire logic [3:0] orB = isImmOr ? imm : acc_ff; // second or operand
  logic [3:0] orRes; // bitwise or result

  // one or gate per nibble bit
  genvar gi;
  generate
    for (gi = 0; gi < 4; gi = gi + 1)
    begin : g_or
      assign orRes[gi] = orA[gi] | orB[gi];
    end
  endgenerate

  // rotations pass through the carry: five-bit ring of carry and nibble
  wire logic [3:0] rolRes = {memRdata[`LOR_NIB_MSB-1:`LOR_NIB_LSB], carry_ff};
  wire logic [3:0] rorRes = {carry_ff, memRdata[`LOR_NIB_MSB:`LOR_NIB_LSB+1]};
  wire logic rolCarry = memRdata[`LOR_NIB_MSB];
  wire logic rorCarry = memRdata[`LOR_NIB_LSB];

  // result that lands in the accumulator
  wire logic [3:0] result = isRotL ? rolRes : (isRotR ? rorRes : orRes);
  wire logic doAcc = isMemOr || isImmOr || isRot;
  // write-back destinations
  wire logic doMemWr = (op == lor_pkg::LOR_ORWB_MEM) || isRot;
  wire logic doWrWr = (op == lor_pkg::LOR_ORWB_IMM);

  // next values
  wire logic [3:0] nxt_acc = doAcc ? result : acc_ff;
  wire logic nxt_zero = doAcc ? (result == `LOR_NIB_ZERO) : zero_ff;
  // or leaves the carry alone; only rotations move it
  wire logic nxt_carry = isRotL ? rolCarry : (isRotR ? rorCarry : carry_ff);

  // accumulator and flags; every instruction retires in one cycle
  always_ff @(posedge mclk)
  begin
    if (srst)
    begin
      acc_ff <= `LOR_ACC_RST;
      carry_ff <= `LOR_FLAG_RST;
      zero_ff <= `LOR_FLAG_RST;
    end
    else
    begin
      acc_ff <= nxt_acc;
      carry_ff <= nxt_carry;
      zero_ff <= nxt_zero;
    end
  end

  // memory write port; registered so the strobe and data are clean,
  // at the cost of the write landing one edge after the read
  always_ff @(posedge mclk)
  begin
    if (srst)
    begin
      memWe_ff <= `LOR_FLAG_RST;
      memWaddr_ff <= `LOR_ADDR_RST;
      memWdata_ff <= `LOR_ACC_RST;
    end
    else
    begin
      memWe_ff <= doMemWr;
      memWaddr_ff <= memAddr;
      memWdata_ff <= result;
    end
  end

  // working register write port
  always_ff @(posedge mclk)
  begin
    if (srst)
    begin
      wrWe_ff <= `LOR_FLAG_RST;
      wrWaddr_ff <= `LOR_WSEL_RST;
      wrWdata_ff <= `LOR_ACC_RST;
    end
    else
    begin
      wrWe_ff <= doWrWr;
      wrWaddr_ff <= wrSel;
      wrWdata_ff <= result;
    end
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  assign acc = acc_ff;
  assign carryFlag = carry_ff;
  assign zeroFlag = zero_ff;
  assign memWe = memWe_ff;
  assign memWaddr = memWaddr_ff;
  assign memWdata = memWdata_ff;
  assign wrWe = wrWe_ff;
  assign wrWaddr = wrWaddr_ff;
  assign wrWdata = wrWdata_ff;

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  a_or_mem_acc:
  assert property (@(posedge mclk) disable iff (srst)
    (op == lor_pkg::LOR_OR_MEM) |=> (acc == ($past(memRdata) | $past(acc))) && !memWe && !wrWe)
  else $error("or memory into accumulator wrong");

  a_or_imm_acc:
  assert property (@(posedge mclk) disable iff (srst)
    (op == lor_pkg::LOR_OR_IMM) |=> (acc == ($past(wrRdata) | $past(imm))) && !memWe && !wrWe)
  else $error("or immediate into accumulator wrong");

  a_orwb_mem_both:
  assert property (@(posedge mclk) disable iff (srst)
    (op == lor_pkg::LOR_ORWB_MEM) |=> memWe && (memWdata == acc) && (memWaddr == $past(memAddr))
      && (acc == ($past(memRdata) | $past(acc))))
  else $error("or write-back to memory wrong");

  a_orwb_imm_both:
  assert property (@(posedge mclk) disable iff (srst)
    (op == lor_pkg::LOR_ORWB_IMM) |=> wrWe && (wrWdata == acc) && (wrWaddr == $past(wrSel))
      && (acc == ($past(wrRdata) | $past(imm))))
  else $error("or write-back to working register wrong");

  a_rot_left_ring:
  assert property (@(posedge mclk) disable iff (srst)
    isRotL |=> memWe && (memWdata == acc) && ({carryFlag, acc} == {$past(memRdata), $past(carryFlag)}))
  else $error("rotate left through carry wrong");

  a_rot_right_ring:
  assert property (@(posedge mclk) disable iff (srst)
    isRotR |=> memWe && (memWdata == acc) && ({acc, carryFlag} == {$past(carryFlag), $past(memRdata)}))
  else $error("rotate right through carry wrong");

  a_zero_flag_track:
  assert property (@(posedge mclk) disable iff (srst)
    doAcc |=> (zeroFlag == (acc == `LOR_NIB_ZERO)))
  else $error("zero flag does not match result");

  a_or_keeps_carry:
  assert property (@(posedge mclk) disable iff (srst)
    (isMemOr || isImmOr) |=> $stable(carryFlag))
  else $error("or changed the carry flag");

endmodule

//--- verilog/lor_consts.svh
`ifndef LOR_CONSTS_SVH
`define LOR_CONSTS_SVH

// ----------------------------------------------------------------
// opcode fields of the instruction word
// ----------------------------------------------------------------
`define LOR_OP9_HI 15
`define LOR_OP9_LO 7
`define LOR_OP8_LO 8

// nine-bit opcodes (memory operand forms)
`define LOR_OP_OR_MEM 9'h074
`define LOR_OP_ORWB_MEM 9'h076
`define LOR_OP_ROT_LEFT 9'h099
`define LOR_OP_ROT_RIGHT 9'h09B

// eight-bit opcodes (working register with immediate)
`define LOR_OP_OR_IMM 8'h3E
`define LOR_OP_ORWB_IMM 8'h3F

// ----------------------------------------------------------------
// operand fields
// ----------------------------------------------------------------
`define LOR_ADDR_HI 6
`define LOR_ADDR_LO 0
`define LOR_IMM_HI 7
`define LOR_IMM_LO 4
`define LOR_WSEL_HI 3
`define LOR_WSEL_LO 0
`define LOR_NIB_MSB 3
`define LOR_NIB_LSB 0

// ----------------------------------------------------------------
// reset values
// ----------------------------------------------------------------
`define LOR_ACC_RST 4'h0
`define LOR_FLAG_RST 1'h0
`define LOR_ADDR_RST 7'h00
`define LOR_WSEL_RST 4'h0
`define LOR_NIB_ZERO 4'h0

`endif

//--- verilog/lor_pkg.sv
package lor_pkg;

  // decoded operation of the current instruction word
  typedef enum logic [2:0] {
    LOR_NONE,
    LOR_OR_MEM,
    LOR_OR_IMM,
    LOR_ORWB_MEM,
    LOR_ORWB_IMM,
    LOR_ROT_LEFT,
    LOR_ROT_RIGHT
  } lor_op_t;

endpackage

//--- bench/lor_mem_model.sv
`timescale 1ns/100ps
// ----------------------------------------
// data memory and working registers
// ----------------------------------------
module lor_mem_model (
  input wire logic mclk,
  input wire logic [6:0] memAddr,
  output logic [3:0] memRdata,
  input wire logic [3:0] wrSel,
  output logic [3:0] wrRdata,
  input wire logic memWe,
  input wire logic [6:0] memWaddr,
  input wire logic [3:0] memWdata,
  input wire logic wrWe,
  input wire logic [3:0] wrWaddr,
  input wire logic [3:0] wrWdata
);
  logic [3:0] mem [128]; // data memory nibbles
  logic [3:0] wrf [16]; // working registers
  // fixed fill so no read is ever unknown
  initial
  begin
    for (int i = 0; i < 128; i++)
      mem[i] = 4'(i * 7);
    for (int i = 0; i < 16; i++)
      wrf[i] = 4'(i * 5);
  end
  // reads are combinational; no forwarding of a write in flight
  assign memRdata = mem[memAddr];
  assign wrRdata = wrf[wrSel];
  // writes land at the edge after the strobe rises
  always @(posedge mclk)
  begin
    if (memWe)
      mem[memWaddr] <= memWdata;
    if (wrWe)
      wrf[wrWaddr] <= wrWdata;
  end
endmodule

//--- bench/lor_datapath_test.sv
`timescale 1ns/100ps
module lor_datapath_test;
  // ----------------------------------------
  // signals and bookkeeping
  // ----------------------------------------
  logic mclk = 1'b0;
  logic srst = 1'b1;
  logic [15:0] instr = 16'h0000;
  logic instrValid = 1'b0;
  logic [6:0] memAddr;
  logic [6:0] memWaddr;
  logic [3:0] memRdata, wrSel, wrRdata, memWdata, wrWaddr, wrWdata, acc;
  logic memWe, wrWe, carryFlag, zeroFlag;
  integer errors = 0;
  integer comparisons = 0;
  integer cycles = 0;
  integer seed = 32'hAE21;
  logic [5:0] shadow = 6'h00; // expected {zero, carry, acc}
  logic [15:0] ops [6] = '{16'h3A00, 16'h3B00, 16'h4C80, 16'h4D80, 16'h3E00, 16'h3F00};
  logic [31:0] r;
  logic [7:0] pend = 8'h00; // expectation of the slot taken at the last edge
  logic [15:0] pendIns = 16'h0000; // instruction word of that slot
  logic pendOn = 1'b0; // a slot still awaits its compare
  always #5 mclk = ~mclk;
  lor_datapath lor_datapath_inst (.mclk, .srst, .instr, .instrValid, .memAddr, .memRdata, .wrSel,
    .wrRdata, .memWe, .memWaddr, .memWdata, .wrWe, .wrWaddr, .wrWdata, .acc, .carryFlag, .zeroFlag);
  lor_mem_model lor_mem_model_inst (.mclk, .memAddr, .memRdata, .wrSel, .wrRdata, .memWe, .memWaddr,
    .memWdata, .wrWe, .wrWaddr, .wrWdata);
  // ----------------------------------------
  // expectation, compare and close
  // ----------------------------------------
  // returns {memWe, wrWe, zero, carry, acc}; unknown words keep all state
  function automatic logic [7:0] predict(logic [15:0] ins, logic [3:0] m, logic [3:0] w, logic [5:0] s);
    logic [3:0] res;
    logic c;
    logic [1:0] we;
    res = s[3:0];
    c = s[4];
    we = 2'b00;
    if (ins[15:7] == 9'h074)
      res = m | s[3:0];
    else if (ins[15:7] == 9'h076)
      {we, res} = {2'b10, m | s[3:0]};
    else if (ins[15:7] == 9'h099)
      {we, c, res} = {2'b10, m, s[4]};
    else if (ins[15:7] == 9'h09B)
      {we, res, c} = {2'b10, s[4], m};
    else if (ins[15:8] == 8'h3E)
      res = w | ins[7:4];
    else if (ins[15:8] == 8'h3F)
      {we, res} = {2'b01, w | ins[7:4]};
    else
      return {2'b00, s};
    return {we, res == 4'h0, c, res};
  endfunction
  task automatic chk(input string name, input logic [27:0] e, input logic [27:0] g);
    comparisons = comparisons + 1;
    if (g !== e)
    begin
      errors = errors + 1;
      $display("[FAIL] %s expected %h seen %h", name, e, g);
    end
  endtask
  task automatic wrap_up;
    if (errors == 0 && comparisons > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  // outputs of the slot taken at the last rising edge still stand at the falling edge
  task automatic settle;
    if (pendOn)
    begin
      chk("result", pend, {memWe, wrWe, zeroFlag, carryFlag, acc});
      if (pend[7])
        chk("memWrite", {pendIns[6:0], pend[3:0]}, {memWaddr, memWdata});
      if (pend[6])
        chk("wrWrite", {pendIns[3:0], pend[3:0]}, {wrWaddr, wrWdata});
      shadow = pend[5:0];
    end
    pendOn = 1'b0;
  endtask
  // one instruction slot driven at the rising edge; memory is peeked before the taking edge,
  // so a write-back still in flight yields the stale nibble, as the design sees it
  task automatic step(input logic [15:0] ins, input logic v);
    instr <= ins;
    instrValid <= v;
    @(negedge mclk);
    settle();
    pend = {2'b00, shadow};
    if (v)
      pend = predict(ins, lor_mem_model_inst.mem[ins[6:0]], lor_mem_model_inst.wrf[ins[3:0]], shadow);
    pendIns = ins;
    pendOn = 1'b1;
    @(posedge mclk);
  endtask
  // entered and left at a rising edge; the slot in flight is compared first
  task automatic do_reset;
    srst <= 1'b1;
    instrValid <= 1'b0;
    @(negedge mclk);
    settle();
    @(posedge mclk);
    @(negedge mclk);
    chk("reset", 28'h0, {memWe, wrWe, zeroFlag, carryFlag, acc, memWaddr, memWdata, wrWaddr, wrWdata});
    shadow = 6'h00;
    @(posedge mclk);
    srst <= 1'b0;
    @(posedge mclk);
  endtask
  // hang guard
  always @(posedge mclk)
  begin
    cycles <= cycles + 1;
    if (cycles == 2000)
    begin
      errors = errors + 1;
      wrap_up();
    end
  end
  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial
  begin
    @(posedge mclk);
    do_reset();
    lor_mem_model_inst.mem[5] = 4'h3;
    lor_mem_model_inst.mem[9] = 4'h9;
    lor_mem_model_inst.mem[1] = 4'h0;
    lor_mem_model_inst.wrf[0] = 4'h0;
    // corners: zero result, back-to-back same address, rotates, refusals
    step(16'h3E00, 1'b1);
    step(16'h3E40, 1'b1);
    step(16'h3B05, 1'b1);
    step(16'h3B05, 1'b1);
    step(16'h4C89, 1'b1);
    step(16'h4D81, 1'b1);
    step(16'h4D81, 1'b1);
    step(16'h3F2A, 1'b1);
    step(16'h0000, 1'b1);
    step(16'h3A05, 1'b0);
    // random mix; small address pool forces collisions
    for (int i = 0; i < 600; i++)
    begin
      r = $random(seed);
      if (i == 300)
        do_reset();
      if (r[31:29] > 3'h5)
        step(r[15:0], r[28]);
      else
        step(ops[r[31:29]] | (r[31:29] < 3'h4 ? {9'h000, r[6:0] & (r[20] ? 7'h7F : 7'h07)} : {8'h00, r[7:0]}),
          r[27:25] != 3'h0);
    end
    @(negedge mclk);
    settle();
    wrap_up();
  end
endmodule
